// ---- verilog/tig_params.svh ----
// Constants of the transmit interpolator and gain configuration block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TIG_PARAMS_SVH
`define TIG_PARAMS_SVH

// Device register offsets on the configuration link
`define TIG_REG_TX_ATTEN      5'h0a
`define TIG_REG_TX_FORMAT     5'h0c
`define TIG_REG_ROUTE_SELECT  5'h0e
`define TIG_REG_MIRROR_GAIN   5'h10
`define TIG_REG_SECOND_STAGE  5'h11
`define TIG_REG_OFFSET_CURR   5'h12
`define TIG_REG_PWRDN_CTRL    5'h13

// Device register reset values
`define TIG_RST_TX_ATTEN      8'h00
`define TIG_RST_TX_FORMAT     8'h01
`define TIG_RST_ROUTE_SELECT  8'h00
`define TIG_RST_MIRROR_GAIN   8'h44
`define TIG_RST_SECOND_STAGE  8'h43
`define TIG_RST_OFFSET_CURR   8'h00
`define TIG_RST_PWRDN_CTRL    8'h00

// Field positions and limits
`define TIG_FMT_FACTOR_HI     7
`define TIG_FMT_FACTOR_LO     6
`define TIG_FMT_TWOS_BIT      0
`define TIG_ROUTE_AMP_OFF_BIT 0
`define TIG_MG_ENABLE_BIT     7
`define TIG_PWRDN_ENABLE_BIT  7
`define TIG_PRIMARY_MAX       3'h4
`define TIG_FIRST_STAGE_MAX   3'h4
`define TIG_SECOND_STAGE_MAX  3'h6
`define TIG_THIRD_STAGE_MAX   3'h5
`define TIG_ATTEN_MAX         6'h27
`define TIG_AMP_STEP_CODES    6'h0c

// Rates and pipeline latency (latency in converter update clocks)
`define TIG_MAX_INPUT_MSPS    80
`define TIG_MAX_UPDATE_MSPS   200
`define TIG_CLK_MHZ           40
`define TIG_LAT_F2_UPDATE     10'h02b
`define TIG_LAT_F4_UPDATE     10'h060

// Host register offsets on AHB-Lite
`define TIG_HOST_CTRL         5'h00
`define TIG_HOST_REGCMD       5'h04
`define TIG_HOST_REGSTAT      5'h08
`define TIG_HOST_TXDATA       5'h0c
`define TIG_HOST_FIFOSTAT     5'h10
`define TIG_HOST_CTRL_RST     32'h0000_0000

`endif

// ---- verilog/tig_pkg.sv ----
// Types of the transmit interpolator and gain configuration block.
// Assumes tig_params.svh on the include path.
`include "tig_params.svh"
package tig_pkg;
  typedef enum logic [1:0] {
    TIG_F4   = 2'b00,
    TIG_F2   = 2'b01,
    TIG_F1   = 2'b10,
    TIG_FRSV = 2'b11
  } tig_factor_t;

  typedef enum logic [0:0] {
    TIG_CFG_IDLE = 1'b0,
    TIG_CFG_WAIT = 1'b1
  } tig_cfg_state_t;

  typedef logic signed [11:0] tig_word_t;
endpackage

// ---- verilog/tig_link_if.sv ----
// Link between the modem back end controller and the transmit device.
// Assumes both ends run on the same hclk.
`timescale 1ns/1ps
`default_nettype none
interface tig_link_if;
  import tig_pkg::*;
  logic        hd_mode;
  tig_word_t   tx_word;
  logic        tx_valid;
  logic        tx_take;
  logic [4:0]  cfg_addr;
  logic [7:0]  cfg_wdata;
  logic        cfg_write;
  logic        cfg_read;
  logic [7:0]  cfg_rdata;
  logic        cfg_rvalid;

  modport dev  (input hd_mode, tx_word, tx_valid, cfg_addr, cfg_wdata, cfg_write, cfg_read,
                output tx_take, cfg_rdata, cfg_rvalid);
  modport host (output hd_mode, tx_word, tx_valid, cfg_addr, cfg_wdata, cfg_write, cfg_read,
                input tx_take, cfg_rdata, cfg_rvalid);
endinterface
`default_nettype wire

// ---- verilog/tig_fifo.sv ----
// Word FIFO with valid and ready on both sides.
// Assumes one clock; DEPTH a power of two.
`timescale 1ns/1ps
`default_nettype none
module tig_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        count
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("tig_fifo: bad WIDTH or DEPTH");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // Honest full and empty from pointer difference
  assign count     = wr_ptr - rd_ptr;
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/tig_tx_device.sv ----
// Transmit device end: half-band interpolator and mirror gain configuration.
// Assumes hclk is the converter update clock and the link partner keeps its rules.
`timescale 1ns/1ps
`default_nettype none
`include "tig_params.svh"
module tig_tx_device
  import tig_pkg::*;
#(
  parameter int CLK_MHZ = `TIG_CLK_MHZ,
  parameter int C1 [11] = '{1290, -420, 236, -150, 100, -66, 42, -26, 15, -8, 11},
  parameter int C2 [3]  = '{1200, -200, 24}
) (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  tig_link_if.dev     link,
  output tig_word_t   conv_word,
  output logic        conv_valid,
  output logic        converter_powerdown,
  output logic        amp_enable,
  output logic [2:0]  interp_factor,
  output logic [2:0]  primary_gain,
  output logic [7:0]  secondary_gain_q,
  output logic [2:0]  primary_offset_current,
  output logic [2:0]  secondary_offset_current,
  output logic [3:0]  dac_atten,
  output logic [1:0]  amp_atten_step
);
  initial begin
    if (CLK_MHZ > `TIG_MAX_UPDATE_MSPS || CLK_MHZ < 1) $error("tig_tx_device: clock out of range");
  end

  function automatic tig_word_t sat12(input logic signed [31:0] v);
    if (v > 32'sd2047) return 12'sh7ff;
    if (v < -32'sd2048) return -12'sh800;
    return v[11:0];
  endfunction

  function automatic logic [2:0] clamp3(input logic [2:0] v, input logic [2:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  // Product of three stage codes, widened first so it cannot wrap
  function automatic logic [7:0] gain_q(input logic [2:0] g1, input logic [2:0] g2, input logic [2:0] g3);
    return {5'h00, g1} * {5'h00, g2} * {5'h00, g3};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] tx_atten_reg;
  logic [7:0] tx_format_interp_control;
  logic [7:0] tx_output_route_select;
  logic [7:0] mirror_gain_control;
  logic [7:0] secondary_stage_gain;
  logic [7:0] offset_current_control;
  logic [7:0] powerdown_control;

  // Register writes from the configuration link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_atten_reg             <= `TIG_RST_TX_ATTEN;
      tx_format_interp_control <= `TIG_RST_TX_FORMAT;
      tx_output_route_select   <= `TIG_RST_ROUTE_SELECT;
      mirror_gain_control      <= `TIG_RST_MIRROR_GAIN;
      secondary_stage_gain     <= `TIG_RST_SECOND_STAGE;
      offset_current_control   <= `TIG_RST_OFFSET_CURR;
      powerdown_control        <= `TIG_RST_PWRDN_CTRL;
    end else if (link.cfg_write) begin
      if (link.cfg_addr == `TIG_REG_TX_ATTEN) begin
        tx_atten_reg <= {2'h0, link.cfg_wdata[5:0]};
      end else if (link.cfg_addr == `TIG_REG_TX_FORMAT) begin
        tx_format_interp_control <= {link.cfg_wdata[7:4], 1'b0, link.cfg_wdata[2:0]};
      end else if (link.cfg_addr == `TIG_REG_ROUTE_SELECT) begin
        tx_output_route_select <= {link.cfg_wdata[7], 6'h00, link.cfg_wdata[0]};
      end else if (link.cfg_addr == `TIG_REG_MIRROR_GAIN) begin
        mirror_gain_control <= {link.cfg_wdata[7:4], 1'b0, link.cfg_wdata[2:0]};
      end else if (link.cfg_addr == `TIG_REG_SECOND_STAGE) begin
        secondary_stage_gain <= {1'b0, link.cfg_wdata[6:4], 1'b0, link.cfg_wdata[2:0]};
      end else if (link.cfg_addr == `TIG_REG_OFFSET_CURR) begin
        offset_current_control <= {1'b0, link.cfg_wdata[6:4], 1'b0, link.cfg_wdata[2:0]};
      end else if (link.cfg_addr == `TIG_REG_PWRDN_CTRL) begin
        powerdown_control <= link.cfg_wdata;
      end
    end
  end

  // Read answer one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.cfg_rdata  <= 8'h00;
      link.cfg_rvalid <= 1'b0;
    end else begin
      link.cfg_rvalid <= link.cfg_read;
      if (link.cfg_read) begin
        if (link.cfg_addr == `TIG_REG_TX_ATTEN) link.cfg_rdata <= tx_atten_reg;
        else if (link.cfg_addr == `TIG_REG_TX_FORMAT) link.cfg_rdata <= tx_format_interp_control;
        else if (link.cfg_addr == `TIG_REG_ROUTE_SELECT) link.cfg_rdata <= tx_output_route_select;
        else if (link.cfg_addr == `TIG_REG_MIRROR_GAIN) link.cfg_rdata <= mirror_gain_control;
        else if (link.cfg_addr == `TIG_REG_SECOND_STAGE) link.cfg_rdata <= secondary_stage_gain;
        else if (link.cfg_addr == `TIG_REG_OFFSET_CURR) link.cfg_rdata <= offset_current_control;
        else if (link.cfg_addr == `TIG_REG_PWRDN_CTRL) link.cfg_rdata <= powerdown_control;
        else link.cfg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate control
  tig_factor_t factor;
  logic [1:0]  phase;
  logic [1:0]  phase_last;
  logic        in_tick;
  logic        s1_edge;
  tig_word_t   in_word;

  // factor decode, reserved code runs as 4
  assign factor     = tig_factor_t'(tx_format_interp_control[`TIG_FMT_FACTOR_HI:`TIG_FMT_FACTOR_LO]);
  assign phase_last = (factor == TIG_F2) ? 2'h1 : (factor == TIG_F1) ? 2'h0 : 2'h3;
  assign in_tick    = (phase == 2'h0);
  assign s1_edge    = (factor == TIG_F2) || !phase[0];
  assign interp_factor = (factor == TIG_F2) ? 3'h2 : (factor == TIG_F1) ? 3'h1 : 3'h4;
  // one input word consumed per input period
  assign link.tx_take = in_tick;
  // Straight binary converted to twos complement; no word gives midscale
  assign in_word = !link.tx_valid ? 12'sh000 :
                   tx_format_interp_control[`TIG_FMT_TWOS_BIT] ? link.tx_word :
                   {~link.tx_word[11], link.tx_word[10:0]};

  // Phase counter over one input period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= 2'h0;
    end else begin
      phase <= (phase >= phase_last) ? 2'h0 : phase + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-band stages
  tig_word_t          hist1 [22];
  tig_word_t          hist2 [6];
  tig_word_t          s1_word;
  logic               s1_tick;
  tig_word_t          s2_word;
  logic signed [31:0] acc1;
  logic signed [31:0] acc2;

  // 43-tap and 11-tap symmetric odd phases
  always_comb begin
    acc1 = '0;
    for (int k = 0; k < 11; k++) begin
      acc1 = acc1 + C1[k] * (32'(hist1[10-k]) + 32'(hist1[11+k]));
    end
    acc2 = '0;
    for (int k = 0; k < 3; k++) begin
      acc2 = acc2 + C2[k] * (32'(hist2[2-k]) + 32'(hist2[3+k]));
    end
  end

  // first stage doubles the input rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 22; i++) hist1[i] <= 12'sh000;
      s1_word <= 12'sh000;
      s1_tick <= 1'b0;
    end else begin
      s1_tick <= s1_edge;
      if (in_tick) begin
        for (int i = 1; i < 22; i++) hist1[i] <= hist1[i-1];
        hist1[0] <= in_word;
        s1_word  <= sat12(acc1 >>> 11);
      end else if (s1_edge) begin
        s1_word <= hist1[11];
      end
    end
  end

  // second stage doubles again for factor 4
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 6; i++) hist2[i] <= 12'sh000;
      s2_word <= 12'sh000;
    end else if (s1_tick) begin
      for (int i = 1; i < 6; i++) hist2[i] <= hist2[i-1];
      hist2[0] <= s1_word;
      s2_word  <= sat12(acc2 >>> 11);
    end else begin
      s2_word <= hist2[3];
    end
  end

  // one output word every update clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_word  <= 12'sh000;
      conv_valid <= 1'b0;
    end else begin
      conv_valid <= !converter_powerdown;
      if (factor == TIG_F1) conv_word <= in_word;
      else if (factor == TIG_F2) conv_word <= s1_word;
      else conv_word <= s2_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-duplex power-down
  logic [9:0] idle_cnt;
  logic [9:0] drain_lat;
  logic [9:0] pd_limit;

  assign drain_lat = (factor == TIG_F1) ? 10'h000 : (factor == TIG_F2) ? `TIG_LAT_F2_UPDATE :
                     `TIG_LAT_F4_UPDATE;
  assign pd_limit  = drain_lat + ({3'h0, powerdown_control[6:0]} * {7'h00, interp_factor});

  // power down once the last word has drained
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt            <= 10'h000;
      converter_powerdown <= 1'b0;
    end else begin
      if (in_tick && link.tx_valid) idle_cnt <= 10'h000;
      else if (idle_cnt != 10'h3ff) idle_cnt <= idle_cnt + 10'h001;
      converter_powerdown <= link.hd_mode && powerdown_control[`TIG_PWRDN_ENABLE_BIT] &&
                             !(in_tick && link.tx_valid) && (idle_cnt >= pd_limit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain and attenuation settings
  logic       mg_on;
  logic [5:0] atten_code;
  logic [1:0] amp_step;
  assign mg_on = mirror_gain_control[`TIG_MG_ENABLE_BIT];

  // route bit clear feeds the current amplifier
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      amp_enable <= 1'b0;
    end else begin
      amp_enable <= !tx_output_route_select[`TIG_ROUTE_AMP_OFF_BIT] && !converter_powerdown;
    end
  end

  // default gains unless enable bit is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_gain     <= 3'h0;
      secondary_gain_q <= 8'h00;
    end else begin
      primary_gain <= clamp3(mg_on ? mirror_gain_control[2:0] : 3'(`TIG_RST_MIRROR_GAIN),
                             `TIG_PRIMARY_MAX);
      secondary_gain_q <= mg_on ?
        gain_q(clamp3(mirror_gain_control[6:4], `TIG_FIRST_STAGE_MAX),
               clamp3(secondary_stage_gain[6:4], `TIG_SECOND_STAGE_MAX),
               clamp3(secondary_stage_gain[2:0], `TIG_THIRD_STAGE_MAX)) :
        gain_q(3'(`TIG_RST_MIRROR_GAIN >> 4), 3'(`TIG_RST_SECOND_STAGE >> 4), 3'(`TIG_RST_SECOND_STAGE));
    end
  end

  // zero setting leaves the source off
  assign primary_offset_current   = offset_current_control[2:0];
  assign secondary_offset_current = offset_current_control[6:4];

  // split of attenuation over converter and amplifier
  assign atten_code = (tx_atten_reg[5:0] > `TIG_ATTEN_MAX) ? `TIG_ATTEN_MAX : tx_atten_reg[5:0];
  assign amp_step   = (atten_code >= (`TIG_AMP_STEP_CODES * 6'h2)) ? 2'h2 :
                      (atten_code >= `TIG_AMP_STEP_CODES) ? 2'h1 : 2'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_atten      <= 4'h0;
      amp_atten_step <= 2'h0;
    end else if (tx_output_route_select[`TIG_ROUTE_AMP_OFF_BIT]) begin
      dac_atten      <= tx_atten_reg[3:0];
      amp_atten_step <= 2'h0;
    end else begin
      dac_atten      <= 4'(atten_code - (`TIG_AMP_STEP_CODES * {4'h0, amp_step}));
      amp_atten_step <= amp_step;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/tig_tx_host.sv ----
// Back end controller end: AHB-Lite registers, transmit FIFO, link master.
// Assumes one AHB-Lite master and the device answering reads one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "tig_params.svh"
module tig_tx_host
  import tig_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  tig_link_if.host         link
);
  localparam int CW = $clog2(DEPTH) + 1;
  initial begin
    if (CW > 8) $error("tig_tx_host: DEPTH too large for status field");
  end

  logic           dp_valid;
  logic           dp_write;
  logic [4:0]     dp_addr;
  logic           wr_en;
  logic [31:0]    ctrl;
  logic           refused;
  logic [7:0]     last_rdata;
  tig_cfg_state_t cfg_state;
  logic           busy;
  logic           fifo_in_ready;
  logic           fifo_out_valid;
  logic [11:0]    fifo_out_data;
  logic [CW-1:0]  fifo_count;
  logic           cmd_go;
  logic           cmd_bad;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave; stalls a data write while the FIFO is full
  assign hresp     = 1'b0;
  assign hreadyout = !(dp_valid && dp_write && dp_addr == `TIG_HOST_TXDATA && !fifo_in_ready);
  assign wr_en     = dp_valid && dp_write && hreadyout;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 5'h00;
      hrdata   <= 32'h0000_0000;
    end else if (hready) begin
      dp_valid <= hsel && htrans[1] && (hsize == 3'h2);
      dp_write <= hwrite;
      dp_addr  <= haddr[4:0];
      if (haddr[31:5] != 27'h0) hrdata <= 32'h0000_0000;
      else if (haddr[4:0] == `TIG_HOST_CTRL) hrdata <= ctrl;
      else if (haddr[4:0] == `TIG_HOST_REGSTAT) hrdata <= {22'h0, refused, busy, last_rdata};
      else if (haddr[4:0] == `TIG_HOST_FIFOSTAT)
        hrdata <= {22'h0, !fifo_out_valid, !fifo_in_ready, 8'(fifo_count)};
      else hrdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and refusal flag
  // bypass only in half-duplex, code 11 never sent
  assign cmd_go  = wr_en && dp_addr == `TIG_HOST_REGCMD && !busy;
  assign cmd_bad = !hwdata[16] && hwdata[12:8] == `TIG_REG_TX_FORMAT &&
                   (hwdata[7:6] == 2'b11 || (hwdata[7:6] == 2'b10 && !ctrl[0]));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl    <= `TIG_HOST_CTRL_RST;
      refused <= 1'b0;
    end else begin
      if (wr_en && dp_addr == `TIG_HOST_CTRL) ctrl <= {30'h0, hwdata[1:0]};
      // Set wins over the software clear
      if (cmd_go && cmd_bad) refused <= 1'b1;
      else if (wr_en && dp_addr == `TIG_HOST_REGSTAT && hwdata[9]) refused <= 1'b0;
    end
  end
  assign link.hd_mode = ctrl[0];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration link sequencer
  assign busy = (cfg_state == TIG_CFG_WAIT) || link.cfg_write || link.cfg_read;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_state      <= TIG_CFG_IDLE;
      link.cfg_addr  <= 5'h00;
      link.cfg_wdata <= 8'h00;
      link.cfg_write <= 1'b0;
      link.cfg_read  <= 1'b0;
      last_rdata     <= 8'h00;
    end else begin
      link.cfg_write <= 1'b0;
      link.cfg_read  <= 1'b0;
      case (cfg_state)
        TIG_CFG_IDLE: begin
          if (cmd_go && !cmd_bad) begin
            link.cfg_addr  <= hwdata[12:8];
            link.cfg_wdata <= hwdata[7:0];
            link.cfg_write <= !hwdata[16];
            link.cfg_read  <= hwdata[16];
            if (hwdata[16]) cfg_state <= TIG_CFG_WAIT;
          end
        end
        TIG_CFG_WAIT: begin
          if (link.cfg_rvalid) begin
            last_rdata <= link.cfg_rdata;
            cfg_state  <= TIG_CFG_IDLE;
          end
        end
        default: cfg_state <= TIG_CFG_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO; device pulls one word per input period
  tig_fifo #(.WIDTH(12), .DEPTH(DEPTH)) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (dp_valid && dp_write && dp_addr == `TIG_HOST_TXDATA),
    .in_ready  (fifo_in_ready),
    .in_data   (hwdata[11:0]),
    .out_valid (fifo_out_valid),
    .out_ready (link.tx_take && ctrl[1]),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );
  assign link.tx_valid = fifo_out_valid && ctrl[1];
  assign link.tx_word  = fifo_out_data;
endmodule
`default_nettype wire

// ---- test/tig_link_sva.sv ----
// Checker of the controller to device link.
// Assumes one clock, placed beside the link.
`timescale 1ns/1ps
`default_nettype none
module tig_link_sva (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hd_mode,
  input wire logic       tx_take,
  input wire logic [4:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic       cfg_write,
  input wire logic       cfg_read,
  input wire logic [7:0] cfg_rdata,
  input wire logic       cfg_rvalid
);
  logic [1:0] fac;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////
  // Mirror of the factor field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fac <= 2'b00;
    end else if (cfg_write && cfg_addr == 5'h0c) begin
      fac <= cfg_wdata[7:6];
    end
  end
  //////////////////////
  // Link checks
  fmt_code_a: assert property (cfg_write && cfg_addr == 5'h0c |-> cfg_wdata[7:6] != 2'b11)
    else $error("reserved code");
  byp_hd_a: assert property (cfg_write && cfg_addr == 5'h0c && cfg_wdata[7:6] == 2'b10 |-> hd_mode)
    else $error("bypass not hd");
  byp_rate_a: assert property (tx_take && $past(tx_take) && $past(hresetn) |-> fac == 2'b10 || $past(fac) == 2'b10)
    else $error("take early");
  f2_rate_a: assert property (tx_take && fac == 2'b01 ##1 fac == 2'b01 && !cfg_write |=> tx_take)
    else $error("take missing");
  f4_gap_a: assert property (tx_take && fac == 2'b00 && $stable(fac) |=> (!tx_take || fac != 2'b00) [*3])
    else $error("take early");
  rd_ans_a: assert property (cfg_read |=> cfg_rvalid)
    else $error("no answer");
  rd_cause_a: assert property (cfg_rvalid |-> $past(cfg_read))
    else $error("stray answer");
  rsv_bit_a: assert property (cfg_rvalid && $past(cfg_addr) == 5'h10 |-> !cfg_rdata[3])
    else $error("unused bit set");
endmodule
`default_nettype wire

// ---- test/tb_tx_interpolator_gain_config.sv ----
// Bench joining controller and device over the link.
// Assumes a 40 MHz hclk and one AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
module tb_tx_interpolator_gain_config;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r;
  logic        hrdy, pd, cv, amp;
  logic [2:0]  fac, pg, po, so;
  logic [7:0]  sq;
  logic [3:0]  da;
  logic [1:0]  ast;
  logic [7:0]  rv [7] = '{8'h00, 8'h01, 8'h00, 8'h44, 8'h43, 8'h00, 8'h00};
  logic [4:0]  ra [7] = '{5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h11, 5'h12, 5'h13};
  int          bad_count = 0;
  int          n_tests = 0;
  tig_link_if lk ();
  //////////////////////
  // Clock and parts
  always #12.5 hclk = ~hclk;
  tig_tx_host i_tig_tx_host (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hrdy), .hreadyout(hrdy), .hresp(), .hrdata, .link(lk.host));
  tig_tx_device i_tig_tx_device (.hclk, .hresetn, .link(lk.dev), .conv_word(), .conv_valid(cv),
    .converter_powerdown(pd), .amp_enable(amp), .interp_factor(fac), .primary_gain(pg),
    .secondary_gain_q(sq), .primary_offset_current(po), .secondary_offset_current(so),
    .dac_atten(da), .amp_atten_step(ast));
  tig_link_sva i_tig_link_sva (.hclk, .hresetn, .hd_mode(lk.hd_mode), .tx_take(lk.tx_take),
    .cfg_addr(lk.cfg_addr), .cfg_wdata(lk.cfg_wdata), .cfg_write(lk.cfg_write),
    .cfg_read(lk.cfg_read), .cfg_rdata(lk.cfg_rdata), .cfg_rvalid(lk.cfg_rvalid));
  //////////////////////
  // Compare and tally
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  // One AHB-Lite single transfer, read data into r
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hwrite <= w;
    haddr <= a;
    htrans <= 2'b10;
    do @(posedge hclk); while (!hrdy);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (!hrdy);
    r = hrdata;
  endtask
  // Device command, then wait while busy
  task automatic cmd(input logic [31:0] c);
    ahb(1'b1, 32'h4, c);
    ahb(1'b0, 32'h8, 32'h0);
    do ahb(1'b0, 32'h8, 32'h0); while (r[8]);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cmd({19'h0, a, d});
  endtask
  task automatic rd(input logic [4:0] a);
    cmd({15'h0, 1'b1, 3'h0, a, 8'h00});
  endtask
  // Verdict
  task automatic close_out;
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    bad_count++;
    close_out;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i]);
      chk("reset", r[9:0], {2'h0, rv[i]});
    end
    chk("pg", 10'(pg), 10'h4);
    chk("sg", 10'(sq), 10'h30);
    chk("fac", 10'(fac), 10'h4);
    wr(5'h0c, 8'hc1);
    chk("rsv", r[9:0], 10'h200);
    ahb(1'b1, 32'h8, 32'h200);
    wr(5'h0c, 8'h81);
    chk("hd", r[9:0], 10'h200);
    ahb(1'b1, 32'h8, 32'h200);
    ahb(1'b1, 32'h0, 32'h1);
    wr(5'h0c, 8'h81);
    chk("f1", 10'(fac), 10'h1);
    wr(5'h0c, 8'h41);
    chk("f2", 10'(fac), 10'h2);
    wr(5'h10, 8'h22);
    chk("noen", 10'(pg), 10'h4);
    wr(5'h10, 8'h8f);
    rd(5'h10);
    chk("rb", r[9:0], 10'h087);
    wr(5'h10, 8'ha2);
    wr(5'h11, 8'h53);
    chk("pg2", 10'(pg), 10'h2);
    chk("sg2", 10'(sq), 10'h1e);
    wr(5'h0e, 8'h01);
    chk("amp", 10'(amp), 10'h0);
    wr(5'h12, 8'h53);
    chk("off", 10'({so, po}), 10'h2b);
    wr(5'h0a, 8'h6d);
    rd(5'h0a);
    chk("atn", r[9:0], 10'h02d);
    chk("dac", 10'({ast, da}), 10'h00d);
    wr(5'h0e, 8'h00);
    chk("amp2", 10'({amp, ast, da}), 10'h06f);
    ahb(1'b0, 32'h14, 32'h0);
    chk("unm", r[9:0], 10'h0);
    wr(5'h0c, 8'h01);
    for (int i = 0; i < 32; i++) begin
      ahb(1'b1, 32'hc, 32'(i));
    end
    ahb(1'b0, 32'h10, 32'h0);
    chk("full", r[9:0], 10'h120);
    ahb(1'b1, 32'h0, 32'h3);
    do ahb(1'b0, 32'h10, 32'h0); while (!r[9]);
    wr(5'h13, 8'h80);
    repeat (120) @(posedge hclk);
    chk("pd", 10'({pd, cv}), 10'h2);
    ahb(1'b1, 32'hc, 32'h5);
    repeat (8) @(posedge hclk);
    chk("pu", 10'({pd, cv}), 10'h1);
    close_out;
  end
endmodule
`default_nettype wire
